/* include/touch_port_map.vh */
/*
  touch_port_map.vh: constants for the touch host register port,
  covering status codes, timing figures and the default bus address.
  Assumes it is included by bare name from the design files.
*/
`ifndef TOUCH_PORT_MAP_VH
`define TOUCH_PORT_MAP_VH

// initialisation interval after reset, in microseconds, and the clock rate
`define INIT_TIME_US    20000
`define SYS_CLK_MHZ     40
`define INIT_CYCLES     (`INIT_TIME_US * `SYS_CLK_MHZ)

// per-transaction status byte returned on the serial data-out line
`define SPI_STAT_OK     8'h00
`define SPI_STAT_BUSY   8'h80

// spi byte positions within a transaction
`define SPI_IDX_ADDR_HI 2'h0
`define SPI_IDX_ADDR_LO 2'h1
`define SPI_IDX_FIRST   2'h2
`define SPI_IDX_LATER   2'h3
`define SPI_RW_BIT      7

// default 7-bit two-wire target address
`define I2C_ADDR_DEF    7'h55

// synchroniser lanes
`define LN_SCK          0
`define LN_SS           1
`define LN_MOSI         2
`define LN_SCL          3
`define LN_SDA          4
`define LN_COUNT        5

`endif

/* src/touch_reg_mem.v */
/*
  touch_reg_mem.v: byte-wide register storage for the host port.
  Assumes a single requester per cycle; read data is registered and
  holds until the next read.
*/
`timescale 1ns/1ps

module touch_reg_mem #(
  parameter AW = 8
) (
  // clock and reset
  input  wire          sys_clk_in,
  input  wire          rst_b_in,
  input  wire          clk_en_in,
  // access port
  input  wire          we_in,
  input  wire          re_in,
  input  wire [AW-1:0] addr_in,
  input  wire [7:0]    wdata_in,
  output reg  [7:0]    rdata_out
);

  reg [7:0] mem [0:(1<<AW)-1];

  // storage array has no reset, like a real register ram
  always @(posedge sys_clk_in)
  begin
    if (clk_en_in && we_in)
      mem[addr_in] <= wdata_in;
  end

  // read data register holds between reads
  always @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rdata_out <= 8'h00;
    else if (clk_en_in && re_in)
      rdata_out <= mem[addr_in];
  end

endmodule

/* src/touch_host_port.v */
/*
  touch_host_port.v: serial register port of a touch controller, reached
  by a host over either spi (mode with rising-edge sampling) or a two-wire
  bus. All pins are sampled by the system clock; spi clock must be slow
  enough to give several system cycles per half period.
*/
`timescale 1ns/1ps
`include "touch_port_map.vh"

module touch_host_port #(
  parameter INIT_CYCLES = `INIT_CYCLES,
  parameter AW          = 8
) (
  // clock, reset, enable
  input  wire       sys_clk_in,
  input  wire       rst_b_in,
  input  wire       clk_en_in,
  // device state
  input  wire       dev_busy_in,
  output reg        init_done_out,
  // stored bus address configuration
  input  wire       cfg_addr_we_in,
  input  wire [6:0] cfg_addr_in,
  // spi pins
  input  wire       spi_sck_in,
  input  wire       spi_ss_b_in,
  input  wire       spi_mosi_in,
  output reg        spi_miso_out,
  output wire       spi_miso_oe_out,
  // two-wire pins
  input  wire       i2c_scl_in,
  input  wire       i2c_sda_in,
  output wire       i2c_sda_out,
  output reg        i2c_sda_oe_out
);

  localparam I_IDLE = 2'd0;
  localparam I_HDR  = 2'd1;
  localparam I_WR   = 2'd2;
  localparam I_RD   = 2'd3;

  function [15:0] next_addr;
    input [15:0] a;
    begin
      next_addr = a + 16'h0001;
    end
  endfunction

  // pin synchronisers: three stages, a change counts when stages 2 and 3 agree
  reg  [`LN_COUNT-1:0] s1_q, s2_q, s3_q, f_q;
  wire [`LN_COUNT-1:0] f_d  = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
  wire [`LN_COUNT-1:0] rise = f_d & ~f_q;
  wire [`LN_COUNT-1:0] fall = ~f_d & f_q;
  always @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s1_q <= 5'h1f;
      s2_q <= 5'h1f;
      s3_q <= 5'h1f;
      f_q  <= 5'h1f;
    end
    else if (clk_en_in)
    begin
      s1_q <= {i2c_sda_in, i2c_scl_in, spi_mosi_in, spi_ss_b_in, spi_sck_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  // initialisation timer; 32 bits covers the default count easily
  reg [31:0] init_cnt_q;
  always @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      init_cnt_q    <= 32'h0000_0000;
      init_done_out <= 1'b0;
    end
    else if (clk_en_in && !init_done_out)
    begin
      if (init_cnt_q >= INIT_CYCLES - 1)
        init_done_out <= 1'b1;
      init_cnt_q <= init_cnt_q + 32'h0000_0001;
    end
  end

  // two-wire target address, reloadable from configuration
  reg [6:0] i2c_addr_q;
  always @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      i2c_addr_q <= `I2C_ADDR_DEF;
    else if (clk_en_in && cfg_addr_we_in)
      i2c_addr_q <= cfg_addr_in;
  end

  // ---------------- spi side ----------------
  reg  [2:0]  s_bit_q;
  reg  [1:0]  s_idx_q;
  reg  [7:0]  s_rx_q, s_tx_q, s_next_q;
  reg  [15:0] s_ptr_q;
  reg         s_rd_q, s_busy_q;
  reg         s_mre_q, s_mwe_q;
  reg  [15:0] s_maddr_q;
  reg  [7:0]  s_mwd_q;
  wire        ss_act = ~f_q[`LN_SS];
  wire [7:0]  s_byte = {s_rx_q[6:0], f_q[`LN_MOSI]};
  wire [7:0]  mem_rdata;

  assign spi_miso_oe_out = ss_act;

  always @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_bit_q <= 3'h0;  s_idx_q <= 2'h0;  s_rx_q <= 8'h00;  s_tx_q <= 8'h00;
      s_next_q <= 8'h00;  s_ptr_q <= 16'h0000;  s_rd_q <= 1'b0;
      s_busy_q <= 1'b0;  s_mre_q <= 1'b0;  s_mwe_q <= 1'b0;
      s_maddr_q <= 16'h0000;  s_mwd_q <= 8'h00;  spi_miso_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      s_mre_q <= 1'b0;
      s_mwe_q <= 1'b0;
      if (!ss_act)
      begin
        s_bit_q  <= 3'h0;
        s_idx_q  <= 2'h0;
        s_next_q <= 8'h00;
      end
      else if (rise[`LN_SCK])
      begin
        s_rx_q  <= s_byte;
        s_bit_q <= s_bit_q + 3'h1;
        if (s_bit_q == 3'h7)
        begin
          if (s_idx_q != `SPI_IDX_LATER)
            s_idx_q <= s_idx_q + 2'h1;
          if (s_idx_q == `SPI_IDX_ADDR_HI)
          begin
            // first address byte; top bit is direction
            s_ptr_q[15:8] <= {1'b0, s_byte[6:0]};
            s_rd_q        <= s_byte[`SPI_RW_BIT];
          end
          else if (s_idx_q == `SPI_IDX_ADDR_LO)
          begin
            s_ptr_q[7:0] <= s_byte;
            // busy or not yet initialised decides the status
            s_busy_q <= dev_busy_in | ~init_done_out;
            s_next_q <= (dev_busy_in | ~init_done_out) ? `SPI_STAT_BUSY : `SPI_STAT_OK;
            // prefetch first read byte while the dummy byte runs
            s_mre_q   <= s_rd_q;
            s_maddr_q <= {s_ptr_q[15:8], s_byte};
          end
          else if (s_rd_q)
          begin
            // data follows the dummy byte; busy returns zeros
            s_next_q <= s_busy_q ? 8'h00 : mem_rdata;
            if (!s_busy_q)
            begin
              s_ptr_q   <= next_addr(s_ptr_q);
              s_maddr_q <= next_addr(s_ptr_q);
              s_mre_q   <= 1'b1;
            end
          end
          else
          begin
            s_next_q <= 8'h00;
            if (!s_busy_q)
            begin
              s_mwe_q   <= 1'b1;
              s_maddr_q <= s_ptr_q;
              s_mwd_q   <= s_byte;
              s_ptr_q   <= next_addr(s_ptr_q);
            end
          end
        end
      end
      else if (fall[`LN_SCK])
      begin
        if (s_bit_q == 3'h0)
        begin
          spi_miso_out <= s_next_q[7];
          s_tx_q       <= {s_next_q[6:0], 1'b0};
        end
        else
        begin
          spi_miso_out <= s_tx_q[7];
          s_tx_q       <= {s_tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // ---------------- two-wire side ----------------
  reg  [1:0]  i_st_q;
  reg  [3:0]  i_bit_q;
  reg  [1:0]  i_n_q;
  reg  [7:0]  i_rx_q, i_tx_q;
  reg  [15:0] i_start_q, i_ptr_q;
  reg         i_ack_q, i_rw_q;
  reg         i_mre_q, i_mwe_q;
  reg  [15:0] i_maddr_q;
  reg  [7:0]  i_mwd_q;
  wire        scl_hi = f_q[`LN_SCL];
  wire [7:0]  i_byte = {i_rx_q[6:0], f_q[`LN_SDA]};

  // open-drain: only ever pull low
  assign i2c_sda_out = 1'b0;

  always @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      i_st_q <= I_IDLE;  i_bit_q <= 4'h0;  i_n_q <= 2'h0;  i_rx_q <= 8'h00;
      i_tx_q <= 8'h00;  i_start_q <= 16'h0000;  i_ptr_q <= 16'h0000;
      i_ack_q <= 1'b0;  i_rw_q <= 1'b0;  i_mre_q <= 1'b0;  i_mwe_q <= 1'b0;
      i_maddr_q <= 16'h0000;  i_mwd_q <= 8'h00;  i2c_sda_oe_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      i_mre_q <= 1'b0;
      i_mwe_q <= 1'b0;
      // start and stop are data edges while the clock is high
      if (scl_hi && fall[`LN_SDA])
      begin
        i_st_q  <= I_HDR;
        i_bit_q <= 4'h0;
        i_n_q   <= 2'h0;
        i2c_sda_oe_out <= 1'b0;
      end
      else if (scl_hi && rise[`LN_SDA])
      begin
        i_st_q <= I_IDLE;
        i2c_sda_oe_out <= 1'b0;
      end
      else if (i_st_q != I_IDLE && rise[`LN_SCL])
      begin
        i_rx_q  <= i_byte;
        i_bit_q <= (i_bit_q == 4'h8) ? 4'h0 : i_bit_q + 4'h1;
        if (i_bit_q == 4'h7)
        begin
          case (i_st_q)
            I_HDR:
            begin
              // answer only our address after initialisation
              i_ack_q <= (i_byte[7:1] == i2c_addr_q) && init_done_out;
              i_rw_q  <= i_byte[0];
              // every read restarts at the stored start address
              i_ptr_q   <= i_start_q;
              i_maddr_q <= i_start_q;
              i_mre_q   <= i_byte[0];
            end
            I_WR:
            begin
              i_ack_q <= 1'b1;
              if (i_n_q != 2'h2)
                i_n_q <= i_n_q + 2'h1;
              if (i_n_q == 2'h0)
                i_start_q[15:8] <= i_byte;
              else if (i_n_q == 2'h1)
              begin
                i_start_q[7:0] <= i_byte;
                i_ptr_q        <= {i_start_q[15:8], i_byte};
              end
              else
              begin
                i_mwe_q   <= 1'b1;
                i_maddr_q <= i_ptr_q;
                i_mwd_q   <= i_byte;
                i_ptr_q   <= next_addr(i_ptr_q);
              end
            end
            default:
              i_ack_q <= 1'b0;
          endcase
        end
        else if (i_bit_q == 4'h8)
        begin
          if (i_st_q == I_HDR)
          begin
            if (!i_ack_q)
              i_st_q <= I_IDLE;
            else if (i_rw_q)
            begin
              i_st_q <= I_RD;
              i_tx_q <= mem_rdata;
              i_ptr_q   <= next_addr(i_ptr_q);
              i_maddr_q <= next_addr(i_ptr_q);
              i_mre_q   <= 1'b1;
            end
            else
              i_st_q <= I_WR;
          end
          else if (i_st_q == I_RD)
          begin
            // master ack asks for the next consecutive register
            if (f_q[`LN_SDA])
              i_st_q <= I_IDLE;
            else
            begin
              i_tx_q    <= mem_rdata;
              i_ptr_q   <= next_addr(i_ptr_q);
              i_maddr_q <= next_addr(i_ptr_q);
              i_mre_q   <= 1'b1;
            end
          end
        end
      end
      else if (i_st_q != I_IDLE && fall[`LN_SCL])
      begin
        // ack slot: receiving pulls low, transmitting releases for the host
        if (i_bit_q == 4'h8)
          i2c_sda_oe_out <= i_ack_q && (i_st_q != I_RD);
        else if (i_st_q == I_RD)
        begin
          i2c_sda_oe_out <= ~i_tx_q[7];
          i_tx_q         <= {i_tx_q[6:0], 1'b0};
        end
        else
          i2c_sda_oe_out <= 1'b0;
      end
    end
  end

  // shared storage; spi wins a same-cycle clash, which the buses never cause in practice
  wire          m_we    = s_mwe_q | i_mwe_q;
  wire          m_re    = s_mre_q | i_mre_q;
  wire [AW-1:0] m_addr  = (s_mwe_q | s_mre_q) ? s_maddr_q[AW-1:0] : i_maddr_q[AW-1:0];
  wire [7:0]    m_wdata = s_mwe_q ? s_mwd_q : i_mwd_q;

  touch_reg_mem #(
    .AW (AW)
  ) u_mem (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .clk_en_in  (clk_en_in),
    .we_in      (m_we),
    .re_in      (m_re),
    .addr_in    (m_addr),
    .wdata_in   (m_wdata),
    .rdata_out  (mem_rdata)
  );

endmodule

/* verification/host_link_model.sv */
/* host link model: the host processor as spi and two-wire master.
   assumes a system clock fast against the link; called at clock edges. */
`timescale 1ns/1ps

module host_link_model (
  // clock and port pins
  input  wire  sys_clk_in,
  input  wire  spi_miso_in,
  input  wire  spi_miso_oe_in,
  input  wire  sda_oe_in,
  input  wire  sda_dat_in,
  output logic sck_out,
  output logic ss_b_out,
  output logic mosi_out,
  output logic scl_out,
  output wire  sda_out
);
  localparam int Q       = 26;   // quarter two-wire bit, keeps both phases over 1250 ns
  localparam int RECOVER = 1120; // 28 us between selects
  logic       sda_drv = 1'b1;
  logic [7:0] rx;
  event       got;
  // open drain, pull-up wins when nobody pulls; the device's data level counts when enabled
  assign sda_out = sda_drv & (~sda_oe_in | sda_dat_in);
  // idle: clocks high, select off
  initial
  begin
    sck_out  = 1'b1;
    ss_b_out = 1'b1;
    mosi_out = 1'b0;
    scl_out  = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // select frames a transfer; released data line flips
  task automatic spi_sel(input logic on);
    @(posedge sys_clk_in);
    ss_b_out <= ~on;
    mosi_out <= ~mosi_out;
    w(on ? 4 : RECOVER);
  endtask
  // drive on the falling clock, sample late in the high phase
  // an undriven miso reads inverted so a missing enable shows up
  task automatic spi_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sck_out  <= 1'b0;
      mosi_out <= b[i];
      w(4);
      sck_out  <= 1'b1;
      w(4);
      rx = {rx[6:0], spi_miso_oe_in ? spi_miso_in : ~spi_miso_in};
    end
    -> got;
  endtask
  task automatic i2c_start();
    sda_drv <= 1'b0;
    w(Q);
    scl_out <= 1'b0;
    w(Q);
  endtask
  task automatic i2c_stop();
    sda_drv <= 1'b0;
    w(Q);
    scl_out <= 1'b1;
    w(Q);
    sda_drv <= 1'b1;
    w(2 * Q);
  endtask
  // data set while scl low, sampled late in the high phase
  task automatic i2c_bit(input logic b, output logic s);
    sda_drv <= b;
    w(Q);
    scl_out <= 1'b1;
    w(2 * Q);
    s = sda_out;
    scl_out <= 1'b0;
    w(Q);
  endtask
  // byte plus acknowledge; rd releases sda, last answers with nack
  task automatic i2c_byte(input logic [7:0] tx, input logic rd, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      i2c_bit(rd | tx[i], s);
      rx = {rx[6:0], s};
    end
    i2c_bit(~rd | last, s);
    if (!rd)
      rx = {7'h00, s};
    -> got;
  endtask
endmodule

/* verification/touch_host_port_checker.sv */
/* host port checker: pin timing relations of the register port.
   assumes it is bound onto the port; pins pass a 3-stage synchroniser. */
`timescale 1ns/1ps

module touch_host_port_checker #(
  parameter INIT_CYCLES = 800000
) (
  // clock and reset
  input wire       sys_clk_in,
  input wire       rst_b_in,
  input wire       clk_en_in,
  // device side
  input wire       dev_busy_in,
  input wire       init_done_out,
  input wire       cfg_addr_we_in,
  input wire [6:0] cfg_addr_in,
  // spi pins
  input wire       spi_sck_in,
  input wire       spi_ss_b_in,
  input wire       spi_mosi_in,
  input wire       spi_miso_out,
  input wire       spi_miso_oe_out,
  // two-wire pins
  input wire       i2c_scl_in,
  input wire       i2c_sda_in,
  input wire       i2c_sda_out,
  input wire       i2c_sda_oe_out
);
  logic [31:0] cnt_q;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // enabled cycles since release; saturates so it never wraps
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      cnt_q <= 32'h0000_0000;
    else if (clk_en_in && cnt_q != 32'hffff_ffff)
      cnt_q <= cnt_q + 32'h0000_0001;
  // select steady for longer than the synchroniser needs
  sequence ss_low_settled;
    !spi_ss_b_in [*6];
  endsequence
  sequence ss_high_settled;
    spi_ss_b_in [*6];
  endsequence
  AST_INIT_EARLY: assert property (cnt_q < INIT_CYCLES - 1 |-> !init_done_out)
    else $error("init done too early");
  AST_INIT_LATE: assert property (cnt_q > INIT_CYCLES + 2 |-> init_done_out)
    else $error("init done too late");
  AST_INIT_HOLD: assert property (init_done_out |=> init_done_out)
    else $error("init done dropped");
  AST_NO_ACK_EARLY: assert property (!init_done_out |-> !i2c_sda_oe_out)
    else $error("sda pulled before init");
  AST_MISO_OE_ON: assert property (ss_low_settled |-> spi_miso_oe_out)
    else $error("miso not driven in frame");
  AST_MISO_OE_OFF: assert property (ss_high_settled |-> !spi_miso_oe_out)
    else $error("miso driven outside frame");
  AST_MISO_ON_FALL: assert property ($changed(spi_miso_out) && !spi_ss_b_in && !$past(spi_ss_b_in, 8)
    |-> !$past(spi_sck_in, 3) || !$past(spi_sck_in, 4)) else $error("miso moved off a falling edge");
  AST_SDA_ON_SCL_LOW: assert property ($changed(i2c_sda_oe_out)
    |-> !$past(i2c_scl_in, 3) || !$past(i2c_scl_in, 4)) else $error("sda moved while scl high");
  // a low enable freezes the init timer and both pin drivers
  AST_FREEZE_HOLD: assert property (!clk_en_in
    |=> $stable(init_done_out) && $stable(spi_miso_out) && $stable(i2c_sda_oe_out))
    else $error("state moved while clock enable low");
endmodule

/* verification/testbench.sv */
/* testbench: runs the host port against the link model; each byte the
   host receives is compared with the oldest expected note.
   assumes the port, the model and the checker are compiled first. */
`timescale 1ns/1ps

module testbench;
  logic        sys_clk_in;
  logic        rst_b_in       = 1'b0;
  logic        clk_en_in      = 1'b1;
  logic        dev_busy_in    = 1'b0;
  logic        cfg_addr_we_in = 1'b0;
  logic [6:0]  cfg_addr_in    = 7'h00;
  wire         spi_sck_in, spi_ss_b_in, spi_mosi_in, i2c_scl_in, i2c_sda_in;
  wire         init_done_out, spi_miso_out, spi_miso_oe_out, i2c_sda_out, i2c_sda_oe_out;
  logic [31:0] seed = 32'hf9fe_b24a;
  logic [14:0] a;
  logic [7:0]  dat [4];
  logic [7:0]  exp_q [$];
  int          bad_count, samples_checked, cycles;
  touch_host_port #(
    .INIT_CYCLES (3000)
  ) dut (
    .sys_clk_in      (sys_clk_in),
    .rst_b_in        (rst_b_in),
    .clk_en_in       (clk_en_in),
    .dev_busy_in     (dev_busy_in),
    .init_done_out   (init_done_out),
    .cfg_addr_we_in  (cfg_addr_we_in),
    .cfg_addr_in     (cfg_addr_in),
    .spi_sck_in      (spi_sck_in),
    .spi_ss_b_in     (spi_ss_b_in),
    .spi_mosi_in     (spi_mosi_in),
    .spi_miso_out    (spi_miso_out),
    .spi_miso_oe_out (spi_miso_oe_out),
    .i2c_scl_in      (i2c_scl_in),
    .i2c_sda_in      (i2c_sda_in),
    .i2c_sda_out     (i2c_sda_out),
    .i2c_sda_oe_out  (i2c_sda_oe_out)
  );
  host_link_model host (
    .sys_clk_in     (sys_clk_in),
    .spi_miso_in    (spi_miso_out),
    .spi_miso_oe_in (spi_miso_oe_out),
    .sda_oe_in      (i2c_sda_oe_out),
    .sda_dat_in     (i2c_sda_out),
    .sck_out        (spi_sck_in),
    .ss_b_out       (spi_ss_b_in),
    .mosi_out       (spi_mosi_in),
    .scl_out        (i2c_scl_in),
    .sda_out        (i2c_sda_in)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic compare(input string what, input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask
  // each finished host byte against the oldest note
  always @(host.got)
    compare("host byte", host.rx, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
  // address first, then status and data; writes flip bit 7 when refused
  task automatic spi_tx(input logic rd, input logic [14:0] ad, input logic [7:0] st, input int n);
    // a write packet never carries more than 32 data bytes
    if (!rd && n > 32)
      n = 32;
    host.spi_sel(1'b1);
    exp_q.push_back(8'h00);
    host.spi_byte({rd, ad[14:8]});
    exp_q.push_back(8'h00);
    host.spi_byte(ad[7:0]);
    for (int k = 0; k < n + rd; k++)
    begin
      exp_q.push_back(k == 0 ? st : (rd && st == 8'h00) ? dat[(k + 3) % 4] : 8'h00);
      host.spi_byte(rd ? 8'(rnd()) : dat[k] ^ st);
    end
    host.spi_sel(1'b0);
  endtask
  // two-wire header; ack is the level expected on the ninth bit
  task automatic hdr(input logic [6:0] ad, input logic rd, input logic ack);
    host.i2c_start();
    exp_q.push_back({7'h00, ack});
    host.i2c_byte({ad, rd}, 1'b0, 1'b0);
  endtask
  task automatic wr(input logic [7:0] v);
    exp_q.push_back(8'h00);
    host.i2c_byte(v, 1'b0, 1'b0);
  endtask
  // read two bytes from the stored start address, nack the last
  task automatic rd23();
    hdr(7'h55, 1'b1, 1'b0);
    for (int i = 2; i < 4; i++)
    begin
      exp_q.push_back(dat[i]);
      host.i2c_byte(8'hff, 1'b1, i == 3);
    end
    host.i2c_stop();
  endtask
  task automatic end_of_test();
    bad_count += exp_q.size();
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    sys_clk_in = 1'b0;
    forever
      #12.5 sys_clk_in = ~sys_clk_in;
  end
  // a hang counts as a mismatch
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    // read before init refused, zeros returned, whatever busy says
    dev_busy_in <= ^rnd();
    spi_tx(1'b1, 15'h0010, 8'h80, 2);
    dev_busy_in <= 1'b0;
    hdr(7'h55, 1'b0, 1'b1);
    host.i2c_stop();
    // enable toggles at random while the links idle; the init count must freeze with it
    for (int i = 0; i < 8000 && init_done_out !== 1'b1; i++)
    begin
      clk_en_in <= ^rnd();
      @(posedge sys_clk_in);
    end
    clk_en_in <= 1'b1;
    a = 15'(rnd());
    foreach (dat[i])
      dat[i] = 8'(rnd());
    // burst write, read back after the dummy byte
    spi_tx(1'b0, a, 8'h00, 4);
    spi_tx(1'b1, a, 8'h00, 4);
    // busy write keeps the old contents
    dev_busy_in <= 1'b1;
    spi_tx(1'b0, a, 8'h80, 4);
    dev_busy_in <= 1'b0;
    spi_tx(1'b1, a, 8'h00, 4);
    // two-wire write at a fresh start address
    dat[2] = 8'(rnd());
    dat[3] = 8'(rnd());
    hdr(7'h55, 1'b0, 1'b0);
    wr(8'h00);
    wr(a[7:0] ^ 8'h80);
    wr(dat[2]);
    wr(dat[3]);
    host.i2c_stop();
    // pointer-only write, then two reads from it
    hdr(7'h55, 1'b0, 1'b0);
    wr(8'h00);
    wr(a[7:0] ^ 8'h80);
    host.i2c_stop();
    repeat (2) rd23();
    // moved target address; the old one goes unanswered
    cfg_addr_in    <= 7'h28 | 7'(rnd() % 8);
    cfg_addr_we_in <= 1'b1;
    @(posedge sys_clk_in);
    cfg_addr_we_in <= 1'b0;
    hdr(7'h55, 1'b0, 1'b1);
    host.i2c_stop();
    hdr(cfg_addr_in, 1'b0, 1'b0);
    host.i2c_stop();
    end_of_test();
  end
endmodule

bind touch_host_port touch_host_port_checker #(
  .INIT_CYCLES (INIT_CYCLES)
) chk (
  .sys_clk_in      (sys_clk_in),
  .rst_b_in        (rst_b_in),
  .clk_en_in       (clk_en_in),
  .dev_busy_in     (dev_busy_in),
  .init_done_out   (init_done_out),
  .cfg_addr_we_in  (cfg_addr_we_in),
  .cfg_addr_in     (cfg_addr_in),
  .spi_sck_in      (spi_sck_in),
  .spi_ss_b_in     (spi_ss_b_in),
  .spi_mosi_in     (spi_mosi_in),
  .spi_miso_out    (spi_miso_out),
  .spi_miso_oe_out (spi_miso_oe_out),
  .i2c_scl_in      (i2c_scl_in),
  .i2c_sda_in      (i2c_sda_in),
  .i2c_sda_out     (i2c_sda_out),
  .i2c_sda_oe_out  (i2c_sda_oe_out)
);
